// ---- tsec_pkg.sv ----
// Package for the two-stage event controller: sizes, event codes, reset mapping.
// Assumes a single core clock and a synchronous active-low reset.
package tsec_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int TSEC_NUM_SRC = 16;
   localparam int TSEC_NUM_GP = 9;
   localparam int TSEC_LVL_W = 4;
   localparam int TSEC_SRC_W = 4;
   localparam int TSEC_ADDR_W = 32;
   localparam logic [3:0] TSEC_GP_FIRST = 4'h7;
   localparam logic [3:0] TSEC_GP_LAST = 4'hf;
   // ----------------------------------------
   // Event levels, highest priority first
   // ----------------------------------------
   localparam logic [3:0] TSEC_EV_EMU = 4'h0;
   localparam logic [3:0] TSEC_EV_RST = 4'h1;
   localparam logic [3:0] TSEC_EV_NMI = 4'h2;
   localparam logic [3:0] TSEC_EV_EXC = 4'h3;
   localparam int TSEC_NUM_EV = 16;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] TSEC_ACTIVE_RST = 16'h0000;
   localparam logic [31:0] TSEC_RETADDR_RST = 32'h0000_0000;
   // Default level for source n: 7 + (n mod 7), keeping 15 and 14 for software
   function automatic logic [3:0] tsec_default_level(input int src);
      tsec_default_level = 4'(7 + (src % 7));
   endfunction
endpackage

// ---- tsec_event_ctrl.sv ----
// Two-stage event controller: peripheral routing stage plus core event stage.
// Assumes the core sequencer acknowledges entries and returns; pin, emulation and peripheral sources are async.
// Functional notes
// - Emulation event puts core into debug mode
// - Watchdog or pin raises unmaskable nonmaskable event
// - Exceptions taken synchronously before instruction completes
// - Interrupts accepted asynchronously from pins, peripherals
// - Each event has own return address register
// - State saved on supervisor stack on entry
// - Peripheral requests route onto general-purpose levels
// - Nine general levels 15..7 plus dedicated events
// - Default mapping after reset, software may rewrite
// - Higher priority event serviced first
// - Nesting: higher priority may preempt running handler
`timescale 1ns/1ps
`default_nettype none
module tsec_event_ctrl
   import tsec_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Asynchronous event sources
   input wire logic [TSEC_NUM_SRC-1:0] periph_irq,
   input wire logic nmi_pin,
   input wire logic emu_req,
   // Synchronous sources from the core
   input wire logic watchdog_expire,
   input wire logic exc_req,
   input wire logic [TSEC_NUM_GP-1:0] soft_raise,
   input wire logic [TSEC_NUM_GP-1:0] gp_mask,
   // Source assignment write port
   input wire logic assign_we,
   input wire logic [TSEC_SRC_W-1:0] assign_src,
   input wire logic [TSEC_LVL_W-1:0] assign_level,
   // Sequencer handshake
   input wire logic [TSEC_ADDR_W-1:0] core_pc,
   input wire logic entry_ack,
   input wire logic ret_req,
   input wire logic [TSEC_LVL_W-1:0] ret_level,
   // Outputs to the sequencer
   output logic event_req,
   output logic [TSEC_LVL_W-1:0] event_level,
   output logic emu_mode,
   output logic save_state,
   output logic [TSEC_ADDR_W-1:0] ret_addr,
   output logic [TSEC_NUM_EV-1:0] active
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [TSEC_NUM_SRC+1:0] sync1_reg;
   logic [TSEC_NUM_SRC+1:0] sync2_reg;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {emu_req, nmi_pin, periph_irq};
         sync2_reg <= sync1_reg;
      end
   end

   // ----------------------------------------
   // Peripheral routing stage
   // ----------------------------------------
   logic [TSEC_LVL_W-1:0] src_level_reg [TSEC_NUM_SRC];
   genvar gi;
   generate
      for (gi = 0; gi < TSEC_NUM_SRC; gi++) begin : g_assign
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               src_level_reg[gi] <= tsec_default_level(gi);
            end else if (assign_we && assign_src == TSEC_SRC_W'(gi) &&
                         assign_level >= TSEC_GP_FIRST) begin
               src_level_reg[gi] <= assign_level;
            end
         end
      end
   endgenerate

   logic [TSEC_NUM_GP-1:0] routed;
   always_comb begin
      routed = '0;
      for (int s = 0; s < TSEC_NUM_SRC; s++) begin
         if (sync2_reg[s]) begin
            routed[src_level_reg[s] - TSEC_GP_FIRST] = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Core event stage: pending latches
   // ----------------------------------------
   logic [TSEC_NUM_EV-1:0] pend_reg;
   logic [TSEC_NUM_EV-1:0] raw;
   logic take;
   logic [TSEC_LVL_W-1:0] win;
   always_comb begin
      raw = '0;
      raw[TSEC_EV_EMU] = sync2_reg[TSEC_NUM_SRC+1];
      raw[TSEC_EV_NMI] = sync2_reg[TSEC_NUM_SRC] | watchdog_expire;
      raw[TSEC_EV_EXC] = exc_req;
      raw[TSEC_GP_LAST:TSEC_GP_FIRST] = routed | soft_raise;
   end

   // ----------------------------------------
   // Entry and return decode
   // ----------------------------------------
   function automatic logic [TSEC_NUM_EV-1:0] level_onehot(input logic [TSEC_LVL_W-1:0] lv);
      level_onehot = '0;
      level_onehot[lv] = 1'b1;
   endfunction

   logic [TSEC_NUM_EV-1:0] enter_hit;
   logic [TSEC_NUM_EV-1:0] ret_hit;
   always_comb begin
      enter_hit = '0;
      ret_hit = '0;
      if (take && entry_ack) begin
         enter_hit = level_onehot(win);
      end
      if (ret_req) begin
         ret_hit = level_onehot(ret_level);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pend_reg <= '0;
      end else begin
         for (int e = 0; e < TSEC_NUM_EV; e++) begin
            if (raw[e]) begin
               pend_reg[e] <= 1'b1;
            end else if (enter_hit[e]) begin
               pend_reg[e] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // Priority resolution
   // ----------------------------------------
   logic [TSEC_NUM_EV-1:0] elig;
   logic [TSEC_NUM_EV-1:0] active_reg;
   always_comb begin
      elig = pend_reg;
      elig[TSEC_GP_LAST:TSEC_GP_FIRST] = pend_reg[TSEC_GP_LAST:TSEC_GP_FIRST] & ~gp_mask;
      elig[TSEC_EV_RST] = 1'b0;
      take = 1'b0;
      win = '0;
      for (int e = TSEC_NUM_EV - 1; e >= 0; e--) begin
         if (elig[e]) begin
            take = 1'b1;
            win = TSEC_LVL_W'(e);
         end
      end
      // Preempt only if strictly higher than every running handler
      for (int a = 0; a < TSEC_NUM_EV; a++) begin
         if (active_reg[a] && TSEC_LVL_W'(a) <= win) begin
            take = 1'b0;
         end
      end
      if (elig[TSEC_EV_NMI] && win == TSEC_EV_NMI && !active_reg[TSEC_EV_EMU] &&
          !active_reg[TSEC_EV_NMI]) begin
         take = 1'b1;
      end
   end

   assign event_req = take;
   assign event_level = win;

   // ----------------------------------------
   // Active handlers and nesting
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         active_reg <= TSEC_ACTIVE_RST;
      end else begin
         for (int e = 0; e < TSEC_NUM_EV; e++) begin
            if (enter_hit[e]) begin
               active_reg[e] <= 1'b1;
            end else if (ret_hit[e]) begin
               active_reg[e] <= 1'b0;
            end
         end
      end
   end
   assign active = active_reg;
   assign emu_mode = active_reg[TSEC_EV_EMU];

   // ----------------------------------------
   // Return addresses and state save
   // ----------------------------------------
   logic [TSEC_ADDR_W-1:0] ret_reg [TSEC_NUM_EV];
   generate
      for (gi = 0; gi < TSEC_NUM_EV; gi++) begin : g_ret
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               ret_reg[gi] <= TSEC_RETADDR_RST;
            end else if (enter_hit[gi]) begin
               ret_reg[gi] <= core_pc;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ret_addr <= TSEC_RETADDR_RST;
         save_state <= 1'b0;
      end else begin
         ret_addr <= ret_reg[ret_level];
         save_state <= take && entry_ack;
      end
   end
endmodule
`default_nettype wire

// ---- tsec_event_ctrl_assertions.sv ----
// Checker for the event controller sequencer side.
// Assumes it is bound to tsec_event_ctrl.
`timescale 1ns/1ps
`default_nettype none
module tsec_event_ctrl_chk
   import tsec_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Core inputs watched
   input wire logic [TSEC_NUM_GP-1:0] gp_mask,
   input wire logic entry_ack,
   input wire logic ret_req,
   input wire logic [TSEC_LVL_W-1:0] ret_level,
   // Outputs watched
   input wire logic event_req,
   input wire logic [TSEC_LVL_W-1:0] event_level,
   input wire logic emu_mode,
   input wire logic save_state,
   input wire logic [TSEC_NUM_EV-1:0] active
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire logic take = event_req && entry_ack;
   chk_save_follows: assert property (take |=> save_state)
      else $error("no save after entry");
   chk_save_cause: assert property (save_state |-> $past(take))
      else $error("save without entry");
   chk_entry_active: assert property (take |=> active[$past(event_level)])
      else $error("entered level not active");
   chk_emu_enter: assert property (take && event_level == TSEC_EV_EMU |=> emu_mode)
      else $error("no emulation mode");
   chk_no_reset_ev: assert property (event_req |-> event_level != TSEC_EV_RST)
      else $error("reset level offered");
   chk_mask_gp: assert property (event_req && event_level >= TSEC_GP_FIRST
      |-> !gp_mask[event_level - TSEC_GP_FIRST]) else $error("masked level offered");
   chk_prio_above: assert property (event_req
      |-> (active & ((16'h0002 << event_level) - 16'h0001)) == 16'h0000)
      else $error("offer not above active");
   chk_ret_clear: assert property (ret_req && !take |=> !active[$past(ret_level)])
      else $error("return left level active");
   cover property (take && event_level == TSEC_EV_NMI);
   cover property (take && event_level == TSEC_EV_EMU);
   cover property (ret_req && active[4'h8]);
   cover property (active[TSEC_EV_EXC] && active[4'hc]);
endmodule
bind tsec_event_ctrl tsec_event_ctrl_chk u_chk (.mclk, .rst_n, .gp_mask, .entry_ack, .ret_req,
   .ret_level, .event_req, .event_level, .emu_mode, .save_state, .active);
`default_nettype wire

// ---- tsec_core_model.sv ----
// Core sequencer model: takes an offered event when the bench allows.
// Assumes the bench holds go for one edge per entry.
`timescale 1ns/1ps
`default_nettype none
module tsec_core_model (
   input wire logic go,
   input wire logic event_req,
   output logic entry_ack
);
   // Acks only while offered; state push and return follow in the bench
   assign entry_ack = event_req & go;
endmodule
`default_nettype wire

// ---- tsec_event_ctrl_test.sv ----
// Bench for the event controller: directed scenarios with a core model.
// Assumes tsec_pkg, checker and core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tsec_event_ctrl_test;
   import tsec_pkg::*;
   logic mclk = 0, rst_n = 0, nmi_pin = 0, emu_req = 0, exc_req = 0, go = 0, assign_we = 0;
   logic entry_ack, ret_req = 0, event_req, emu_mode, save_state, watchdog_expire = 0;
   logic [15:0] periph_irq = 0, active;
   logic [8:0] soft_raise = 0, gp_mask = 0;
   logic [3:0] assign_src = 0, assign_level = 0, ret_level = 0, event_level;
   logic [31:0] core_pc = 0, ret_addr;
   int fail_count = 0, n_compared = 0, cyc = 0;
   tsec_event_ctrl u_dut (.mclk, .rst_n, .periph_irq, .nmi_pin, .emu_req,
      .watchdog_expire, .exc_req, .soft_raise, .gp_mask, .assign_we, .assign_src,
      .assign_level, .core_pc, .entry_ack, .ret_req, .ret_level, .event_req, .event_level,
      .emu_mode, .save_state, .ret_addr, .active);
   tsec_core_model u_core (.go, .event_req, .entry_ack);
   initial forever #2.5 mclk = ~mclk;
   always @(posedge mclk) if (++cyc == 5000) begin
      fail_count++;
      summarize();
   end
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task summarize;
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Wait for an offer, then take it with a one-edge acknowledge
   task enter(input logic [3:0] lv);
      int n;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (event_req !== 1'b1 && n < 40);
      check("event_req", event_req, 1);
      check("event_level", event_level, lv);
      @(posedge mclk) {go, core_pc} <= {1'b1, 28'h00a5c00, lv};
      @(posedge mclk) go <= 1'b0;
      @(negedge mclk) check("save_state", save_state, 1);
      check("active", active[lv], 1);
      check("emu_mode", emu_mode, lv == TSEC_EV_EMU);
   endtask
   // Return from the handler at lv and read back its saved address
   task leave(input logic [3:0] lv);
      @(posedge mclk) {ret_req, ret_level} <= {1'b1, lv};
      @(posedge mclk) ret_req <= 1'b0;
      @(negedge mclk) check("active", active[lv], 0);
      @(negedge mclk) check("ret_addr", ret_addr, {28'h00a5c00, lv});
   endtask
   task serve(input logic [3:0] lv);
      enter(lv);
      leave(lv);
   endtask
   task kick(input logic [15:0] p, input logic [8:0] s, input logic [2:0] d);
      @(posedge mclk) {periph_irq, soft_raise, nmi_pin, emu_req, exc_req} <= {p, s, d};
      @(posedge mclk) {periph_irq, soft_raise, nmi_pin, emu_req, exc_req} <= 28'h0;
   endtask
   task t_gp;
      kick(16'h0001, 9'h000, 3'h0);
      serve(4'h7);
   endtask
   task t_prio;
      @(posedge mclk) gp_mask <= 9'h1ff;
      kick(16'h0002, 9'h080, 3'h0);
      repeat (4) @(posedge mclk);
      @(negedge mclk) check("event_req", event_req, 0);
      @(posedge mclk) gp_mask <= 9'h000;
      serve(4'h8);
      serve(4'he);
   endtask
   task t_nmi;
      @(posedge mclk) gp_mask <= 9'h1ff;
      kick(16'h0004, 9'h000, 3'h4);
      serve(TSEC_EV_NMI);
      @(posedge mclk) gp_mask <= 9'h000;
      serve(4'h9);
   endtask
   task t_emu_exc;
      kick(16'h0000, 9'h000, 3'h1);
      serve(TSEC_EV_EXC);
      kick(16'h0000, 9'h000, 3'h2);
      serve(TSEC_EV_EMU);
   endtask
   task t_remap;
      @(posedge mclk) {assign_we, assign_src, assign_level} <= {1'b1, 4'h3, 4'hc};
      @(posedge mclk) assign_we <= 1'b0;
      kick(16'h0008, 9'h000, 3'h0);
      serve(4'hc);
   endtask
   task t_wdog;
      @(posedge mclk) watchdog_expire <= 1'b1;
      @(posedge mclk) watchdog_expire <= 1'b0;
      serve(TSEC_EV_NMI);
   endtask
   task t_nest;
      kick(16'h0000, 9'h020, 3'h0);
      enter(4'hc);
      kick(16'h0000, 9'h040, 3'h1);
      enter(TSEC_EV_EXC);
      check("active", active, 16'h1008);
      leave(TSEC_EV_EXC);
      @(negedge mclk) check("event_req", event_req, 0);
      leave(4'hc);
      serve(4'hd);
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      t_gp();
      t_prio();
      t_nmi();
      t_emu_exc();
      t_remap();
      t_wdog();
      t_nest();
      summarize();
   end
endmodule
`default_nettype wire
